// [rtl/adc8_conversion_control.sv]
// Purpose: Control logic of an 8-bit successive-approximation converter
// Assumes: AHB-Lite slave, single word transfers, analog comparator outside
// Notes:   Comparator registered once; it follows the trial code within one clock
`timescale 1ns/1ns
module adc8_conversion_control (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // Analog front end
   input  wire logic        i_rc_clk,
   input  wire logic        i_comp_above,
   output logic      [2:0]  o_input_channel_select,
   output logic             o_sample_connect,
   output logic      [7:0]  o_dac_code,
   output logic             o_converter_power_on,
   output logic             o_ref_from_pin,
   output logic      [7:0]  o_analog_pin_mask,
   // Interrupt request to core interrupt logic
   output logic             o_conversion_irq
);
   // Control and status state
   logic [1:0]             conv_clock_select_q;
   logic [2:0]             input_channel_select_q;
   logic                   go_q;
   logic                   resv_q;
   logic                   converter_power_on_q;
   logic [2:0]             pin_use_field_q;
   logic [7:0]             conversion_result_reg_q;
   logic                   conversion_done_flag_q;
   logic                   conversion_irq_enable_q;
   logic                   global_irq_enable_q;

   // Sequencer state
   adc8_pkg::seq_state_t   state_q;
   logic [3:0]             period_q;
   logic [7:0]             sar_q;
   logic [7:0]             trial_q;
   logic                   comp_sync_q;

   // Bus address phase capture
   logic                   wr_pend_q;
   logic [7:0]             addr_q;

   logic                   tick;
   logic                   bus_phase;
   logic                   wr_ctrl;
   logic                   wr_port;
   logic                   wr_result;
   logic                   wr_irq;
   logic                   sw_go_set;
   logic                   sw_go_clear;
   logic                   conv_end;
   logic [7:0]             control_rd;
   logic [7:0]             sar_next;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Bus: zero wait state, always OKAY
   assign bus_phase   = i_hsel && i_hready && i_htrans[1];
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         wr_pend_q <= bus_phase && i_hwrite;
         if (bus_phase) begin
            addr_q <= i_haddr[7:0];
         end
      end
   end

   assign wr_ctrl   = wr_pend_q && hit(addr_q, adc8_pkg::OFS_CONTROL);
   assign wr_port   = wr_pend_q && hit(addr_q, adc8_pkg::OFS_PORT_CFG);
   assign wr_result = wr_pend_q && hit(addr_q, adc8_pkg::OFS_RESULT);
   assign wr_irq    = wr_pend_q && hit(addr_q, adc8_pkg::OFS_IRQ);

   assign sw_go_set   = wr_ctrl && i_hwdata[adc8_pkg::GO_BIT]
                        && i_hwdata[adc8_pkg::ON_BIT];
   assign sw_go_clear = wr_ctrl && !i_hwdata[adc8_pkg::GO_BIT];

   assign control_rd = {conv_clock_select_q, input_channel_select_q, go_q, resv_q,
                        converter_power_on_q};

   // Read data selected from the captured address phase
   always_comb begin
      o_hrdata = 32'h0000_0000;
      case (addr_q)
         adc8_pkg::OFS_CONTROL:  o_hrdata[7:0] = control_rd;
         adc8_pkg::OFS_PORT_CFG: o_hrdata[2:0] = pin_use_field_q;
         adc8_pkg::OFS_RESULT:   o_hrdata[7:0] = conversion_result_reg_q;
         adc8_pkg::OFS_IRQ: begin
            o_hrdata[adc8_pkg::DONE_FLAG_BIT] = conversion_done_flag_q;
            o_hrdata[adc8_pkg::IRQ_EN_BIT]    = conversion_irq_enable_q;
            o_hrdata[adc8_pkg::GIE_BIT]       = global_irq_enable_q;
         end
         default: o_hrdata = 32'h0000_0000;
      endcase
   end

   // Control register fields
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         conv_clock_select_q    <= adc8_pkg::CONTROL_RST[7:6];
         input_channel_select_q <= adc8_pkg::CONTROL_RST[5:3];
         resv_q                 <= adc8_pkg::CONTROL_RST[1];
         converter_power_on_q   <= adc8_pkg::CONTROL_RST[0];
      end else if (wr_ctrl) begin
         conv_clock_select_q    <= i_hwdata[adc8_pkg::CLKSEL_HI:adc8_pkg::CLKSEL_LO];
         input_channel_select_q <= i_hwdata[adc8_pkg::CHAN_HI:adc8_pkg::CHAN_LO];
         resv_q                 <= i_hwdata[adc8_pkg::RESV_BIT];
         converter_power_on_q   <= i_hwdata[adc8_pkg::ON_BIT];
      end
   end

   // Go flag: hardware clear at end, software set or abort
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         go_q <= 1'b0;
      end else if (conv_end) begin
         go_q <= 1'b0;
      end else if (wr_ctrl) begin
         go_q <= sw_go_set;
      end else if (!converter_power_on_q) begin
         go_q <= 1'b0;
      end
   end

   // Pin use field: reset forces every pin analog
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_use_field_q <= adc8_pkg::PIN_USE_RST;
      end else if (wr_port) begin
         pin_use_field_q <= i_hwdata[2:0];
      end
   end

   // Interrupt flag and enables; completion wins over software clear
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         conversion_done_flag_q  <= 1'b0;
         conversion_irq_enable_q <= 1'b0;
         global_irq_enable_q     <= 1'b0;
      end else begin
         if (conv_end) begin
            conversion_done_flag_q <= 1'b1;
         end else if (wr_irq) begin
            conversion_done_flag_q <= i_hwdata[adc8_pkg::DONE_FLAG_BIT];
         end
         if (wr_irq) begin
            conversion_irq_enable_q <= i_hwdata[adc8_pkg::IRQ_EN_BIT];
            global_irq_enable_q     <= i_hwdata[adc8_pkg::GIE_BIT];
         end
      end
   end

   assign o_conversion_irq = conversion_done_flag_q && conversion_irq_enable_q
                             && global_irq_enable_q;

   adc8_tick_gen u_tick_gen (
      .i_core_clk   (i_core_clk),
      .i_resetn     (i_resetn),
      .i_enable     (converter_power_on_q && state_q != adc8_pkg::ST_IDLE),
      .i_clk_select (conv_clock_select_q),
      .i_rc_clk     (i_rc_clk),
      .o_tick       (tick)
   );

   adc8_pin_map u_pin_map (
      .i_pin_use_field (pin_use_field_q),
      .o_analog_mask   (o_analog_pin_mask),
      .o_ref_is_pin    (o_ref_from_pin)
   );

   // Comparator answers our own trial code; two stages would miss a 2-clock bit period
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         comp_sync_q <= 1'b0;
      end else begin
         comp_sync_q <= i_comp_above;
      end
   end

   // Period 0 is the hold period, periods 1..8 resolve bits, 9 finishes
   assign conv_end = (state_q == adc8_pkg::ST_CONVERT) && tick && go_q
                     && (period_q == adc8_pkg::CONV_PERIODS - 4'h1);

   always_comb begin
      sar_next = sar_q;
      if (!comp_sync_q) begin
         sar_next = sar_q & ~trial_q;
      end
   end

   // Conversion sequencer, stepped once per bit period
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q  <= adc8_pkg::ST_IDLE;
         period_q <= 4'h0;
         sar_q    <= 8'h00;
         trial_q  <= 8'h00;
      end else if (!converter_power_on_q) begin
         state_q  <= adc8_pkg::ST_IDLE;
         period_q <= 4'h0;
         trial_q  <= 8'h00;
      end else begin
         case (state_q)
            adc8_pkg::ST_IDLE: begin
               if (sw_go_set || go_q) begin
                  state_q  <= adc8_pkg::ST_CONVERT;
                  period_q <= 4'h0;
                  sar_q    <= 8'h80;
                  trial_q  <= 8'h80;
               end
            end
            adc8_pkg::ST_CONVERT: begin
               if (!go_q || sw_go_clear) begin
                  state_q  <= adc8_pkg::ST_GAP;
                  period_q <= 4'h0;
                  trial_q  <= 8'h00;
               end else if (tick) begin
                  if (conv_end) begin
                     state_q  <= adc8_pkg::ST_GAP;
                     period_q <= 4'h0;
                     trial_q  <= 8'h00;
                  end else begin
                     period_q <= period_q + 4'h1;
                     if (period_q >= 4'h1 && trial_q != 8'h00) begin
                        sar_q   <= sar_next | (trial_q >> 1);
                        trial_q <= trial_q >> 1;
                     end
                  end
               end
            end
            adc8_pkg::ST_GAP: begin
               if (tick) begin
                  if (period_q == adc8_pkg::GAP_PERIODS - 4'h1) begin
                     state_q  <= adc8_pkg::ST_IDLE;
                     period_q <= 4'h0;
                  end else begin
                     period_q <= period_q + 4'h1;
                  end
               end
            end
            default: state_q <= adc8_pkg::ST_IDLE;
         endcase
      end
   end

   // Result only updated by a completed conversion or a software write
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         conversion_result_reg_q <= adc8_pkg::RESULT_RST;
      end else if (conv_end) begin
         conversion_result_reg_q <= sar_q;
      end else if (wr_result) begin
         conversion_result_reg_q <= i_hwdata[7:0];
      end
   end

   // Sample switch closed while idle and on; opened during conversion and gap
   assign o_sample_connect       = converter_power_on_q && state_q == adc8_pkg::ST_IDLE;
   assign o_input_channel_select = input_channel_select_q;
   assign o_dac_code             = sar_q;
   assign o_converter_power_on   = converter_power_on_q;
endmodule

// [rtl/adc8_pin_map.sv]
// Purpose: Decode of the pin use field into analog, digital and reference pins
// Assumes: Eight multiplexed inputs, input 3 is the only reference-capable pin
// Notes:   Purely combinational
`timescale 1ns/1ns
module adc8_pin_map (
   // Configuration
   input  wire logic [2:0] i_pin_use_field,
   // Decoded pin use
   output logic      [7:0] o_analog_mask,
   output logic            o_ref_is_pin
);
   always_comb begin
      o_ref_is_pin = 1'b0;
      case (i_pin_use_field)
         3'h0: o_analog_mask = 8'hff;
         3'h1: begin
            o_analog_mask = 8'hf7;
            o_ref_is_pin  = 1'b1;
         end
         3'h2: o_analog_mask = 8'h1f;
         3'h3: begin
            o_analog_mask = 8'h37;
            o_ref_is_pin  = 1'b1;
         end
         3'h4: o_analog_mask = 8'h0b;
         3'h5: begin
            o_analog_mask = 8'h03;
            o_ref_is_pin  = 1'b1;
         end
         default: o_analog_mask = 8'h00;
      endcase
   end
endmodule

// [rtl/adc8_pkg.sv]
// Purpose: Shared constants for the 8-bit converter control block
// Assumes: AHB-Lite register access, 32-bit data, one register per word
// Notes:   Offsets are byte addresses
package adc8_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_PORT_CFG  = 8'h04;
   localparam logic [7:0] OFS_RESULT    = 8'h08;
   localparam logic [7:0] OFS_IRQ       = 8'h0c;

   // Control register field positions
   localparam int CLKSEL_HI  = 7;
   localparam int CLKSEL_LO  = 6;
   localparam int CHAN_HI    = 5;
   localparam int CHAN_LO    = 3;
   localparam int GO_BIT     = 2;
   localparam int RESV_BIT   = 1;
   localparam int ON_BIT     = 0;

   // Irq register field positions
   localparam int DONE_FLAG_BIT = 0;
   localparam int IRQ_EN_BIT    = 1;
   localparam int GIE_BIT       = 2;

   // Reset values
   localparam logic [7:0] CONTROL_RST  = 8'h00;
   localparam logic [2:0] PIN_USE_RST  = 3'h0;
   localparam logic [7:0] RESULT_RST   = 8'h00;

   // Clock select codes
   localparam logic [1:0] CLK_DIV2  = 2'h0;
   localparam logic [1:0] CLK_DIV8  = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_RC    = 2'h3;

   // Divider terminal counts (ticks every N clocks)
   localparam logic [4:0] DIV2_LAST  = 5'h01;
   localparam logic [4:0] DIV8_LAST  = 5'h07;
   localparam logic [4:0] DIV32_LAST = 5'h1f;

   // Sequence lengths in bit periods
   localparam logic [3:0] CONV_PERIODS = 4'ha;
   localparam logic [3:0] GAP_PERIODS  = 4'h2;
   localparam int         RESULT_BITS  = 8;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_GAP
   } seq_state_t;

endpackage

// [rtl/adc8_tick_gen.sv]
// Purpose: Bit-period tick generator from divided core clock or RC clock
// Assumes: RC clock is asynchronous and much slower than the core clock
// Notes:   One-cycle tick output; counter cleared to zero while disabled
`timescale 1ns/1ns
module adc8_tick_gen (
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_resetn,
   // Control
   input  wire logic       i_enable,
   input  wire logic [1:0] i_clk_select,
   input  wire logic       i_rc_clk,
   // Tick
   output logic            o_tick
);
   logic [4:0] div_q;
   logic [4:0] last;
   logic       rc_meta_q;
   logic       rc_sync_q;
   logic       rc_prev_q;
   logic       div_tick;
   logic       rc_tick;

   always_comb begin
      case (i_clk_select)
         adc8_pkg::CLK_DIV2:  last = adc8_pkg::DIV2_LAST;
         adc8_pkg::CLK_DIV8:  last = adc8_pkg::DIV8_LAST;
         default:             last = adc8_pkg::DIV32_LAST;
      endcase
   end

   assign div_tick = i_enable && (div_q >= last);

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_q <= 5'h00;
      end else if (!i_enable || div_tick) begin
         div_q <= 5'h00;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end

   // RC clock synchroniser and rising-edge detect
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rc_meta_q <= 1'b0;
         rc_sync_q <= 1'b0;
         rc_prev_q <= 1'b0;
      end else begin
         rc_meta_q <= i_rc_clk;
         rc_sync_q <= rc_meta_q;
         rc_prev_q <= rc_sync_q;
      end
   end

   assign rc_tick = i_enable && rc_sync_q && !rc_prev_q;

   assign o_tick = (i_clk_select == adc8_pkg::CLK_RC) ? rc_tick : div_tick;
endmodule

// [tb/adc8_conversion_control_sva.sv]
// Purpose: Port checker for the converter control block
// Assumes: One bus master, hready follows hreadyout
// Notes:   Register writes are tracked to predict decoded outputs
`timescale 1ns/1ns
module adc8_conversion_control_sva (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_resetn,
   // Bus
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   input  wire logic [31:0] o_hrdata,
   input  wire logic        o_hreadyout,
   input  wire logic        o_hresp,
   // Front end
   input  wire logic [2:0]  o_input_channel_select,
   input  wire logic        o_sample_connect,
   input  wire logic        o_converter_power_on,
   input  wire logic        o_ref_from_pin,
   input  wire logic [7:0]  o_analog_pin_mask,
   input  wire logic        o_conversion_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   logic ap;
   logic ctl_wr_q;
   logic cfg_wr_q;
   logic cfg_rd_q;

   function automatic logic [7:0] mask_of(input logic [2:0] c);
      case (c)
         3'h0: mask_of = 8'hff;
         3'h1: mask_of = 8'hf7;
         3'h2: mask_of = 8'h1f;
         3'h3: mask_of = 8'h37;
         3'h4: mask_of = 8'h0b;
         3'h5: mask_of = 8'h03;
         default: mask_of = 8'h00;
      endcase
   endfunction

   assign ap = i_hsel & i_hready & i_htrans[1];

   // Data-phase markers per register
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl_wr_q <= 1'b0;
         cfg_wr_q <= 1'b0;
         cfg_rd_q <= 1'b0;
      end else begin
         ctl_wr_q <= ap & i_hwrite & (i_haddr[7:0] == adc8_pkg::OFS_CONTROL);
         cfg_wr_q <= ap & i_hwrite & (i_haddr[7:0] == adc8_pkg::OFS_PORT_CFG);
         cfg_rd_q <= ap & ~i_hwrite & (i_haddr[7:0] == adc8_pkg::OFS_PORT_CFG);
      end
   end

   property p_bus_okay;
      o_hreadyout && !o_hresp;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or errored");

   property p_power;
      ctl_wr_q |=> o_converter_power_on == $past(i_hwdata[adc8_pkg::ON_BIT]);
   endproperty
   a_power: assert property (p_power) else $error("power bit not followed");

   property p_chan;
      ctl_wr_q |=> o_input_channel_select == $past(i_hwdata[5:3]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel select not followed");

   property p_pins;
      cfg_wr_q |=> o_analog_pin_mask == mask_of($past(i_hwdata[2:0]));
   endproperty
   a_pins: assert property (p_pins) else $error("pin mask decode wrong");

   property p_ref;
      cfg_wr_q |=> o_ref_from_pin == ($past(i_hwdata[0])
                   && !($past(i_hwdata[2]) && $past(i_hwdata[1])));
   endproperty
   a_ref: assert property (p_ref) else $error("reference select wrong");

   property p_rst_pins;
      $rose(i_resetn) |-> o_analog_pin_mask == 8'hff;
   endproperty
   a_rst_pins: assert property (p_rst_pins) else $error("pins not analog after reset");

   property p_off_idle;
      !o_converter_power_on |-> !o_sample_connect;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("sampling while off");

   property p_cfg_read;
      cfg_rd_q |-> o_hrdata[31:3] == 29'h0;
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config upper bits not zero");

   property p_gap;
      $rose(o_conversion_irq) && !o_sample_connect |-> !o_sample_connect [*4];
   endproperty
   a_gap: assert property (p_gap) else $error("acquisition resumed too early");
endmodule

// [tb/adc8_front_model.sv]
// Purpose: Analog front end model with holding capacitor and comparator
// Assumes: Held level sits half a step above its code
// Notes:   Comparator output is junk while the converter is off
`timescale 1ns/1ns
module adc8_front_model (
   // Clock
   input  wire logic        i_core_clk,
   // Input levels and converter controls
   input  wire logic [63:0] i_levels,
   input  wire logic [2:0]  i_chan,
   input  wire logic        i_sample,
   input  wire logic        i_power,
   input  wire logic [7:0]  i_dac_code,
   // Toward the converter
   output logic             o_comp_above,
   output logic             o_rc_clk
);
   logic [7:0] held_q = 8'h00;
   logic       junk_q = 1'b0;

   initial begin
      o_rc_clk = 1'b0;
      forever #203 o_rc_clk = ~o_rc_clk;
   end

   // Capacitor tracks the routed input only while connected
   always @(posedge i_core_clk) begin
      junk_q <= ~junk_q;
      if (i_sample) begin
         held_q <= i_levels[i_chan*8 +: 8];
      end
   end

   assign o_comp_above = i_power ? (held_q >= i_dac_code) : junk_q;
endmodule

// [tb/test_adc8_conversion_control.sv]
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait slave, front end modelled behaviourally
// Notes:   Reads are scored by a monitor from a queue of expectations
`timescale 1ns/1ns
module test_adc8_conversion_control;
   logic        i_core_clk = 1'b0;
   logic        i_resetn   = 1'b0;
   logic        i_hsel     = 1'b0;
   logic [31:0] i_haddr    = 32'h0;
   logic [1:0]  i_htrans   = 2'h0;
   logic        i_hwrite   = 1'b0;
   logic [31:0] i_hwdata   = 32'h0;
   logic [63:0] levels     = 64'h0;
   logic        rd_dp      = 1'b0;
   logic [31:0] o_hrdata, rdata;
   logic        o_hreadyout, o_hresp, o_sample_connect, o_converter_power_on;
   logic        o_ref_from_pin, o_conversion_irq, i_rc_clk, i_comp_above;
   logic [2:0]  o_input_channel_select;
   logic [7:0]  o_dac_code, o_analog_pin_mask, last;
   logic [63:0] exp_q[$];
   int          fails  = 0;
   int          checks = 0;
   int          cyc    = 0;
   localparam logic [7:0] PIN_MASK [8] = '{8'hff, 8'hf7, 8'h1f, 8'h37, 8'h0b, 8'h03, 8'h00, 8'h00};
   localparam int PER [4] = '{2, 8, 32, 0};

   adc8_conversion_control dut_u (
      .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
      .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
      .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
      .i_rc_clk(i_rc_clk), .i_comp_above(i_comp_above),
      .o_input_channel_select(o_input_channel_select), .o_sample_connect(o_sample_connect),
      .o_dac_code(o_dac_code), .o_converter_power_on(o_converter_power_on),
      .o_ref_from_pin(o_ref_from_pin), .o_analog_pin_mask(o_analog_pin_mask),
      .o_conversion_irq(o_conversion_irq));

   adc8_front_model model_u (
      .i_core_clk(i_core_clk), .i_levels(levels), .i_chan(o_input_channel_select),
      .i_sample(o_sample_connect), .i_power(o_converter_power_on), .i_dac_code(o_dac_code),
      .o_comp_above(i_comp_above), .o_rc_clk(i_rc_clk));

   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end

   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Read monitor scores the oldest expectation
   always @(posedge i_core_clk) begin
      logic [63:0] e;
      if (rd_dp && o_hreadyout === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[63:32] !== 32'h0) begin
            chk(o_hrdata & e[63:32], e[31:0] & e[63:32]);
         end
      end
   end

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [31:0] msk, input logic [31:0] ev);
      @(posedge i_core_clk);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_haddr <= {24'h0, a};
      i_hwrite <= wr;
      do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= wd;
      rd_dp <= ~wr;
      if (!wr) exp_q.push_back({msk, ev});
      do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
      rdata = o_hrdata;
      rd_dp <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] ev);
      bus(1'b0, a, 32'h0, msk, ev);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] s, input logic [2:0] c,
                                       input logic g, input logic on);
      ctl = {24'h0, s, c, g, 1'b0, on};
   endfunction

   task automatic wait_sample(output int k);
      k = 0;
      while (o_sample_connect !== 1'b1 && k < 400) begin
         @(posedge i_core_clk);
         k++;
      end
   endtask

   task automatic convert(input logic [1:0] s);
      logic [2:0]  ch;
      logic [31:0] iv;
      int          n, t0, k;
      n = PER[s];
      ch = 3'($urandom % 8);
      last = 8'($urandom);
      iv = (s == adc8_pkg::CLK_DIV8) ? 32'h2 : 32'h6;
      levels[ch*8 +: 8] <= last;
      wr(adc8_pkg::OFS_CONTROL, ctl(s, ch, 1'b0, 1'b1));
      wr(adc8_pkg::OFS_IRQ, iv);
      repeat (200) @(posedge i_core_clk);
      wr(adc8_pkg::OFS_CONTROL, ctl(s, ch, 1'b1, 1'b1));
      t0 = cyc;
      rd(adc8_pkg::OFS_CONTROL, 32'h4, 32'h4);
      k = 0;
      do begin
         rd(adc8_pkg::OFS_CONTROL, 32'h0, 32'h0);
         k++;
      end while (rdata[adc8_pkg::GO_BIT] !== 1'b0 && k < 3000);
      if (n > 0) chk(32'(cyc - t0 >= 9*n && cyc - t0 <= 10*n + 16), 32'h1);
      t0 = cyc;
      wait_sample(k);
      if (n > 0) chk(32'(k >= 2*n - 8 && k <= 2*n + 4), 32'h1);
      rd(adc8_pkg::OFS_CONTROL, 32'hff, ctl(s, ch, 1'b0, 1'b1));
      rd(adc8_pkg::OFS_RESULT, 32'hff, {24'h0, last});
      chk(32'(o_dac_code), 32'(last));
      rd(adc8_pkg::OFS_IRQ, 32'h7, iv | 32'h1);
      chk(32'(o_conversion_irq), 32'(iv == 32'h6));
      wr(adc8_pkg::OFS_IRQ, 32'h6);
      @(posedge i_core_clk);
      chk(32'(o_conversion_irq), 32'h0);
   endtask

   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge i_core_clk);
      fails++;
      stop_test;
   end

   initial begin
      int k;
      void'($urandom(33041));
      repeat (4) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      chk(32'(o_analog_pin_mask), 32'hff);
      rd(adc8_pkg::OFS_CONTROL, 32'hffffffff, 32'h0);
      rd(adc8_pkg::OFS_PORT_CFG, 32'hffffffff, 32'h0);
      rd(adc8_pkg::OFS_RESULT, 32'hffffffff, 32'h0);
      wr(8'h10, 32'hff);
      rd(8'h10, 32'hffffffff, 32'h0);
      for (int c = 0; c < 8; c++) begin
         wr(adc8_pkg::OFS_PORT_CFG, 32'hf8 | c);
         @(posedge i_core_clk);
         chk(32'(o_analog_pin_mask), 32'(PIN_MASK[c]));
         chk(32'(o_ref_from_pin), 32'(c == 1 || c == 3 || c == 5));
         rd(adc8_pkg::OFS_PORT_CFG, 32'hffffffff, 32'(c));
      end
      @(posedge i_core_clk);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_resetn <= 1'b1;
      @(posedge i_core_clk);
      chk(32'(o_analog_pin_mask), 32'hff);
      for (int s = 0; s < 4; s++) begin
         convert(2'(s));
      end
      levels[7:0] <= ~last;
      wr(adc8_pkg::OFS_CONTROL, ctl(adc8_pkg::CLK_DIV32, 3'h0, 1'b0, 1'b1));
      repeat (200) @(posedge i_core_clk);
      wr(adc8_pkg::OFS_CONTROL, ctl(adc8_pkg::CLK_DIV32, 3'h0, 1'b1, 1'b1));
      repeat (100) @(posedge i_core_clk);
      wr(adc8_pkg::OFS_CONTROL, ctl(adc8_pkg::CLK_DIV32, 3'h0, 1'b0, 1'b1));
      @(posedge i_core_clk);
      chk(32'(o_sample_connect), 32'h0);
      wait_sample(k);
      chk(32'(k >= 16 && k <= 96), 32'h1);
      rd(adc8_pkg::OFS_RESULT, 32'hff, {24'h0, last});
      wr(adc8_pkg::OFS_CONTROL, ctl(adc8_pkg::CLK_DIV32, 3'h0, 1'b1, 1'b1));
      repeat (100) @(posedge i_core_clk);
      wr(adc8_pkg::OFS_CONTROL, ctl(adc8_pkg::CLK_DIV32, 3'h0, 1'b0, 1'b0));
      @(posedge i_core_clk);
      chk(32'({o_converter_power_on, o_sample_connect}), 32'h0);
      rd(adc8_pkg::OFS_CONTROL, 32'hff, ctl(adc8_pkg::CLK_DIV32, 3'h0, 1'b0, 1'b0));
      rd(adc8_pkg::OFS_RESULT, 32'hff, {24'h0, last});
      @(posedge i_core_clk);
      stop_test;
   end
endmodule

bind adc8_conversion_control adc8_conversion_control_sva chk_u (
   .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .o_input_channel_select(o_input_channel_select), .o_sample_connect(o_sample_connect),
   .o_converter_power_on(o_converter_power_on), .o_ref_from_pin(o_ref_from_pin),
   .o_analog_pin_mask(o_analog_pin_mask), .o_conversion_irq(o_conversion_irq));
